// ### logic/umb_pkg.sv
// Shared constants, register map and carrier types of the serial block.
package umb_pkg;

  // ****************************************************************
  // Bus shape and register offsets (byte addresses)
  // ****************************************************************
  localparam int ADDR_W = 5;
  localparam int DATA_W = 32;
  localparam int BE_W = 4;
  localparam logic [BE_W-1:0] BE_ALL = 4'hF;
  localparam logic [ADDR_W-1:0] OFS_DATA = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_CSR = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_SHARED = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_DIV_LO = 5'h0C;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STS = 5'h10;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MSK = 5'h14;
  localparam logic [ADDR_W-1:0] OFS_FCTL = 5'h18;

  // ****************************************************************
  // Field layout
  // ****************************************************************
  localparam int CSR_FILTER = 0;
  localparam int CSR_TX_DONE = 6;
  localparam int CSR_RX_DONE = 7;
  localparam int SEL_BIT = 15;
  localparam int RSV_LSB = 12;
  localparam int RSV_W = 3;
  localparam int DIV_W = 12;
  localparam int DIVH_W = 4;
  localparam int DIVL_W = 8;
  localparam int DIVH_LSB = 8;
  localparam int FC_W = 8;
  localparam int FC_POL = 0;
  localparam int FC_SIZE_LSB = 1;
  localparam int FC_SIZE_W = 2;
  localparam int FC_STOP2 = 3;
  localparam int FC_NINE = 4;
  localparam int FC_SYNC = 6;
  localparam int IRQ_W = 3;
  localparam int IRQ_RX = 0;
  localparam int IRQ_TX = 1;
  localparam int IRQ_DROP = 2;
  localparam int RXD_W = 9;
  localparam int TXF_W = 12;

  // ****************************************************************
  // Reset values and timing counts
  // ****************************************************************
  localparam logic [DIVH_W-1:0] DIVH_RST = 4'h0;
  localparam logic [DIVL_W-1:0] DIVL_RST = 8'h00;
  localparam logic [FC_W-1:0] FC_RST = 8'h00;
  localparam logic TXD_IDLE = 1'b1;
  localparam logic WAIT_RST = 1'b1;
  localparam logic [3:0] OVS_MID = 4'h7;
  localparam logic [3:0] OVS_LAST = 4'hF;
  localparam logic [3:0] MIN_BITS = 4'h5;
  localparam logic [3:0] NINE_BITS = 4'h9;
  localparam logic [3:0] ONE_STOP = 4'h1;
  localparam logic [3:0] TWO_STOP = 4'h2;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_START = 2'b01,
    RX_DATA = 2'b10,
    RX_STOP = 2'b11
  } umb_rx_state_e;

  typedef enum logic {
    TX_IDLE = 1'b0,
    TX_RUN = 1'b1
  } umb_tx_state_e;

  typedef struct packed {
    logic read;
    logic write;
    logic [ADDR_W-1:0] address;
    logic [DATA_W-1:0] writedata;
    logic [BE_W-1:0] byteenable;
  } umb_avs_req_s;

  typedef struct packed {
    logic [DATA_W-1:0] readdata;
    logic waitrequest;
  } umb_avs_rsp_s;

endpackage

// ### logic/umb_baud_prescaler.sv
// Baud-rate prescaler: a reloadable down-counter that emits one tick.
`timescale 1ns/100ps
module umb_baud_prescaler #(
  parameter int DIV_W = 12
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic load,
  input wire logic [DIV_W-1:0] divisor,
  output logic tick
);
  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic tick;
  } umb_presc_s;

  umb_presc_s r, nx;

  // A tick is issued every divisor+1 clocks; a load restarts the period.
  always_comb begin
    nx = r;
    nx.tick = 1'b0;
    if (load) begin
      nx.cnt = divisor;
    end else if (r.cnt == '0) begin
      nx.cnt = divisor;
      nx.tick = 1'b1;
    end else begin
      nx.cnt = r.cnt - 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      r <= '0;
    end else begin
      r <= nx;
    end
  end

  assign tick = r.tick;

  reload_now_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    load |=> r.cnt == $past(divisor) && !tick)
    else $error("Prescaler did not reload on divisor low write.");

endmodule

// ### logic/umb_usart_multinode.sv
// Serial transceiver with multi-node address filter and baud registers.
//
// Local design decisions: register access over Avalon-MM and the register addresses.
`timescale 1ns/100ps

module umb_usart_multinode (
  input wire logic SYS_CLK,
  input wire logic SYS_RST,
  input wire umb_pkg::umb_avs_req_s AVS_REQ,
  output umb_pkg::umb_avs_rsp_s AVS_RSP,
  input wire logic RXD,
  input wire logic SYNC_CLOCK_PIN,
  output logic TXD,
  output logic IRQ
);
  import umb_pkg::*;

  typedef struct packed {
    umb_avs_rsp_s rsp;
    logic filter;
    logic rx_full;
    logic tx_done;
    logic [7:0] rx_data;
    logic rx_ninth;
    logic [DIVH_W-1:0] div_hi;
    logic [DIVL_W-1:0] div_lo;
    logic [FC_W-1:0] fctl;
    logic [IRQ_W-1:0] sts;
    logic [IRQ_W-1:0] msk;
    logic irq;
    logic sclk_prev;
    umb_rx_state_e rx_st;
    logic [3:0] rx_tcnt;
    logic [3:0] rx_bcnt;
    logic [RXD_W-1:0] rx_shift;
    umb_tx_state_e tx_st;
    logic [3:0] tx_tcnt;
    logic [3:0] tx_left;
    logic [TXF_W-1:0] tx_shift;
    logic txd;
  } umb_state_s;

  umb_state_s r, nx;

  // ****************************************************************
  // Bus decode and line-side helpers
  // ****************************************************************
  logic req;
  logic acc;
  logic wr_ok;
  logic rd_acc;
  logic [ADDR_W-1:0] adr;
  logic [DATA_W-1:0] wd;
  logic sync_m;
  logic nine;
  logic sclk_rise;
  logic sclk_fall;
  logic samp_edge;
  logic drv_edge;
  logic [3:0] nbits;
  logic tick;
  logic rx_step;
  logic tx_step;
  logic finish;
  logic marker;
  logic keep;
  logic rx_set;
  logic drop_set;
  logic tx_set;
  logic div_lo_wr;
  logic [DIV_W-1:0] presc_div;

  assign req = AVS_REQ.read | AVS_REQ.write;
  // A request is taken on the edge where waitrequest is seen low.
  assign acc = req & ~r.rsp.waitrequest;
  // Partial-lane writes are accepted but change nothing.
  assign wr_ok = acc & AVS_REQ.write & (AVS_REQ.byteenable == BE_ALL);
  assign rd_acc = acc & AVS_REQ.read;
  assign adr = AVS_REQ.address;
  assign wd = AVS_REQ.writedata;
  assign sync_m = r.fctl[FC_SYNC];
  assign nine = r.fctl[FC_NINE];
  assign sclk_rise = SYNC_CLOCK_PIN & ~r.sclk_prev;
  assign sclk_fall = ~SYNC_CLOCK_PIN & r.sclk_prev;
  assign samp_edge = r.fctl[FC_POL] ? sclk_rise : sclk_fall;
  assign drv_edge = r.fctl[FC_POL] ? sclk_fall : sclk_rise;
  assign nbits = nine ? NINE_BITS
                      : MIN_BITS + {2'b00, r.fctl[FC_SIZE_LSB+:FC_SIZE_W]};
  assign rx_step = sync_m ? samp_edge : (tick && r.rx_tcnt == OVS_MID);
  assign tx_step = sync_m ? drv_edge : (tick && r.tx_tcnt == OVS_LAST);
  assign finish = (r.rx_st == RX_STOP) && rx_step;
  assign marker = nine ? r.rx_shift[NINE_BITS-1] : RXD;
  assign keep = ~r.filter | marker;
  assign rx_set = finish & keep;
  assign drop_set = finish & ~keep;
  assign tx_set = (r.tx_st == TX_RUN) && tx_step && r.tx_left == 4'h1;
  assign div_lo_wr = wr_ok && adr == OFS_DIV_LO;
  // The fresh low byte goes straight into the reload, not a cycle late.
  assign presc_div = {r.div_hi, div_lo_wr ? wd[DIVL_W-1:0] : r.div_lo};

  umb_baud_prescaler #(
    .DIV_W(DIV_W)
  ) i_umb_baud_prescaler (
    .sys_clk(SYS_CLK),
    .sys_rst(SYS_RST),
    .load(div_lo_wr),
    .divisor(presc_div),
    .tick(tick)
  );

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb begin
    logic [DATA_W-1:0] rd_val;
    logic [TXF_W-1:0] frame;
    logic [3:0] total;
    rd_val = '0;
    frame = '1;
    total = 4'h1 + nbits + (r.fctl[FC_STOP2] ? TWO_STOP : ONE_STOP);
    nx = r;
    nx.sclk_prev = SYNC_CLOCK_PIN;

    case (adr)
      OFS_DATA: begin
        rd_val[RXD_W-1:0] = {r.rx_ninth, r.rx_data};
      end
      OFS_CSR: begin
        rd_val[CSR_FILTER] = r.filter;
        rd_val[CSR_TX_DONE] = r.tx_done;
        rd_val[CSR_RX_DONE] = r.rx_full;
      end
      OFS_SHARED: begin
        // Select and reserved bits stay zero on read-back.
        rd_val[DIVH_LSB+:DIVH_W] = r.div_hi;
      end
      OFS_DIV_LO: rd_val[DIVL_W-1:0] = r.div_lo;
      OFS_IRQ_STS: rd_val[IRQ_W-1:0] = r.sts;
      OFS_IRQ_MSK: rd_val[IRQ_W-1:0] = r.msk;
      OFS_FCTL: rd_val[FC_W-1:0] = r.fctl;
      default: rd_val = '0;
    endcase

    // One wait cycle, then a single cycle with waitrequest low.
    nx.rsp.waitrequest = ~(req & r.rsp.waitrequest);
    if (req && r.rsp.waitrequest) begin
      nx.rsp.readdata = rd_val;
    end

    if (rd_acc && adr == OFS_DATA) begin
      nx.rx_full = 1'b0;
    end

    if (wr_ok) begin
      case (adr)
        OFS_DATA: begin
          if (r.tx_st == TX_IDLE) begin
            frame[0] = 1'b0;
            for (int i = 0; i < RXD_W; i++) begin
              if (i < int'(nbits)) begin
                frame[i+1] = wd[i];
              end
            end
            nx.tx_shift = frame;
            nx.tx_left = total + 4'h1;
            nx.tx_tcnt = '0;
            nx.tx_st = TX_RUN;
          end
        end
        OFS_CSR: begin
          nx.filter = wd[CSR_FILTER];
          if (wd[CSR_TX_DONE]) begin
            nx.tx_done = 1'b0;
          end
        end
        OFS_SHARED: begin
          if (wd[SEL_BIT]) begin
            nx.fctl = wd[FC_W-1:0];
          end else begin
            nx.div_hi = wd[DIVH_LSB+:DIVH_W];
          end
        end
        OFS_DIV_LO: nx.div_lo = wd[DIVL_W-1:0];
        OFS_IRQ_STS: nx.sts = r.sts & ~wd[IRQ_W-1:0];
        OFS_IRQ_MSK: nx.msk = wd[IRQ_W-1:0];
        default: nx.msk = r.msk;
      endcase
    end

    // Receiver.
    if (r.rx_st != RX_IDLE && tick) begin
      nx.rx_tcnt = r.rx_tcnt + 4'h1;
    end
    case (r.rx_st)
      RX_IDLE: begin
        if (!sync_m && !RXD) begin
          nx.rx_st = RX_START;
          nx.rx_tcnt = '0;
        end else if (sync_m && samp_edge && !RXD) begin
          nx.rx_st = RX_DATA;
          nx.rx_bcnt = '0;
          nx.rx_shift = '0;
        end
      end
      RX_START: begin
        if (rx_step) begin
          nx.rx_st = RXD ? RX_IDLE : RX_DATA;
          nx.rx_bcnt = '0;
          nx.rx_shift = '0;
        end
      end
      RX_DATA: begin
        if (rx_step) begin
          nx.rx_shift[r.rx_bcnt] = RXD;
          nx.rx_bcnt = r.rx_bcnt + 4'h1;
          if (r.rx_bcnt == nbits - 4'h1) begin
            nx.rx_st = RX_STOP;
          end
        end
      end
      RX_STOP: begin
        if (rx_step) begin
          nx.rx_st = RX_IDLE;
          if (keep) begin
            nx.rx_data = r.rx_shift[7:0];
            nx.rx_ninth = nine & r.rx_shift[NINE_BITS-1];
          end
        end
      end
      default: nx.rx_st = RX_IDLE;
    endcase

    // Transmitter: the line changes only on a step.
    if (r.tx_st == TX_RUN && tick) begin
      nx.tx_tcnt = r.tx_tcnt + 4'h1;
    end
    case (r.tx_st)
      TX_IDLE: nx.txd = TXD_IDLE;
      TX_RUN: begin
        if (tx_step) begin
          nx.txd = r.tx_shift[0];
          nx.tx_shift = {1'b1, r.tx_shift[TXF_W-1:1]};
          nx.tx_left = r.tx_left - 4'h1;
          if (r.tx_left == 4'h1) begin
            nx.tx_st = TX_IDLE;
          end
        end
      end
      default: nx.tx_st = TX_IDLE;
    endcase

    // Hardware sets win over a clear in the same cycle.
    if (rx_set) begin
      nx.rx_full = 1'b1;
    end
    if (tx_set) begin
      nx.tx_done = 1'b1;
    end
    nx.sts = nx.sts | {drop_set, tx_set, rx_set};
    nx.irq = |(nx.sts & nx.msk);
  end

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      r <= '0;
      r.rsp.waitrequest <= WAIT_RST;
      r.txd <= TXD_IDLE;
      r.div_hi <= DIVH_RST;
      r.div_lo <= DIVL_RST;
      r.fctl <= FC_RST;
    end else begin
      r <= nx;
    end
  end

  assign AVS_RSP = r.rsp;
  assign TXD = r.txd;
  assign IRQ = r.irq;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (SYS_RST);

  sequence s_shared_wr(logic sel);
    wr_ok && adr == OFS_SHARED && wd[SEL_BIT] == sel;
  endsequence

  sequence s_shared_rd;
    rd_acc && adr == OFS_SHARED;
  endsequence

  bus_answer_a: assert property (req && r.rsp.waitrequest |=>
    !AVS_RSP.waitrequest ##1 AVS_RSP.waitrequest)
    else $error("Bus answer not given in the second cycle.");

  addr_frame_kept_a: assert property (finish && marker |=>
    r.rx_full && r.sts[IRQ_RX] && r.rx_data == $past(r.rx_shift[7:0]))
    else $error("Address frame was not stored.");

  data_frame_drop_a: assert property (finish && r.filter && !marker
    |=> $stable(r.rx_data) && r.sts[IRQ_DROP])
    else $error("Filtered data frame reached the buffer.");

  stop_marker_a: assert property (finish && !nine && RXD && r.filter
    |=> r.rx_full && !r.sts[IRQ_DROP] || $past(r.sts[IRQ_DROP]))
    else $error("Stop-bit marker not taken as address.");

  sync_tx_edge_a: assert property (sync_m && $past(sync_m) &&
    $changed(r.txd) |-> $past(drv_edge))
    else $error("Sync transmit changed off the drive edge.");

  sync_rx_edge_a: assert property (sync_m && $past(sync_m) &&
    r.rx_st == RX_DATA && $changed(r.rx_bcnt) |-> $past(samp_edge))
    else $error("Sync receive sampled off the sample edge.");

  shared_read_a: assert property (s_shared_rd |->
    AVS_RSP.readdata[SEL_BIT] == 1'b0 &&
    AVS_RSP.readdata[RSV_LSB+:RSV_W] == '0)
    else $error("Select or reserved bits read as one.");

  div_hi_write_a: assert property (s_shared_wr(1'b0) |=>
    r.div_hi == $past(wd[DIVH_LSB+:DIVH_W]) && $stable(r.fctl))
    else $error("Divisor high not updated by select-zero write.");

  fctl_write_a: assert property (s_shared_wr(1'b1) |=>
    $stable(r.div_hi) && r.fctl == $past(wd[FC_W-1:0]))
    else $error("Select-one write touched divisor high.");

  irq_level_a: assert property (IRQ == |(r.sts & r.msk))
    else $error("Interrupt output disagrees with status and mask.");

endmodule

// ### verification/umb_node_model.sv
// Far-side serial node: drives sync frames onto the line and captures TXD.
`timescale 1ns/100ps
module umb_node_model (
  input wire logic clk,
  input wire logic pol,
  input wire logic txd,
  output logic rxd,
  output logic sck
);
  logic ph = 1'b0;

  // The node owns the sync clock; it stands still at its idle level
  // between frames, so the block never sees stray edges mid-run.
  assign sck = ph ^ pol;
  initial rxd = 1'b1;

  // ****************************************************************
  // Full-duplex frame exchange
  // ****************************************************************
  // Bit 8 of d is the ninth bit of a nine-bit frame, or the first stop bit
  // (the marker) of an eight-bit frame; two stop bits always follow it.
  task automatic xfer(input logic [8:0] d, output logic [8:0] got);
    logic [11:0] fr;
    fr = {2'b11, d, 1'b0};
    got = 9'h000;
    for (int k = 0; k < 12; k++) begin
      @(posedge clk);
      rxd <= fr[k];
      ph <= 1'b1;
      repeat (4) @(posedge clk);
      if (k >= 1 && k <= 9) begin
        got[k-1] = txd;
      end
      ph <= 1'b0;
      repeat (3) @(posedge clk);
    end
  endtask
endmodule

// ### verification/test_umb_usart_multinode.sv
// Self-checking bench: register map, address filter and sync transfers.
`timescale 1ns/100ps
module test_umb_usart_multinode;
  import umb_pkg::*;

  typedef struct packed {
    logic [ADDR_W-1:0] adr;
    logic [DATA_W-1:0] wd;
    logic [DATA_W-1:0] exp;
  } umb_row_s;

  logic SYS_CLK = 1'b0;
  logic SYS_RST = 1'b1;
  umb_avs_req_s avs_req = '0;
  umb_avs_rsp_s avs_rsp;
  logic rxd;
  logic sck;
  logic txd;
  logic irq;
  logic pol = 1'b0;
  int fails = 0;
  int compares = 0;
  logic [DATA_W-1:0] rd;
  logic [8:0] got;
  logic [8:0] txv;
  umb_row_s rows [6];

  always #5 SYS_CLK = ~SYS_CLK;

  umb_usart_multinode i_umb_usart_multinode (
    .SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST),
    .AVS_REQ(avs_req), .AVS_RSP(avs_rsp),
    .RXD(rxd), .SYNC_CLOCK_PIN(sck),
    .TXD(txd), .IRQ(irq));

  umb_node_model i_umb_node_model (
    .clk(SYS_CLK), .pol(pol), .txd(txd), .rxd(rxd), .sck(sck));

  // ****************************************************************
  // Checking and bus tasks
  // ****************************************************************
  task automatic check(input logic [DATA_W-1:0] g, input logic [DATA_W-1:0] e);
    compares++;
    if (g !== e) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // Called just after a rising edge; holds the request until the edge
  // where waitrequest is seen low, then lets one more edge pass.
  task automatic bus(input logic wr, input logic [ADDR_W-1:0] a,
                     input logic [DATA_W-1:0] d,
                     output logic [DATA_W-1:0] q);
    int n;
    n = 0;
    avs_req.read <= ~wr;
    avs_req.write <= wr;
    avs_req.address <= a;
    avs_req.writedata <= d;
    avs_req.byteenable <= BE_ALL;
    @(posedge SYS_CLK);
    while (avs_rsp.waitrequest !== 1'b0 && n < 50) begin
      @(posedge SYS_CLK);
      n++;
    end
    check({31'h0, avs_rsp.waitrequest}, 32'h0000_0000);
    q = avs_rsp.readdata;
    avs_req.read <= 1'b0;
    avs_req.write <= 1'b0;
    @(posedge SYS_CLK);
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    bus(1'b1, a, d, rd);
  endtask

  task automatic rd_chk(input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] e);
    bus(1'b0, a, 32'h0000_0000, rd);
    check(rd, e);
  endtask

  task automatic give_verdict;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    rows[0] = '{OFS_SHARED, 32'h0000_0A00, 32'h0000_0A00};
    rows[1] = '{OFS_SHARED, 32'h0000_8050, 32'h0000_0A00};
    rows[2] = '{OFS_FCTL, 32'h0000_0000, 32'h0000_0050};
    rows[3] = '{OFS_DIV_LO, 32'h0000_00C5, 32'h0000_00C5};
    rows[4] = '{5'h1C, 32'hFFFF_FFFF, 32'h0000_0000};
    rows[5] = '{OFS_IRQ_MSK, 32'h0000_0007, 32'h0000_0007};
    repeat (6) @(posedge SYS_CLK);
    SYS_RST <= 1'b0;
    @(posedge SYS_CLK);
    check({31'h0, txd}, 32'h0000_0001);
    check({31'h0, irq}, 32'h0000_0000);
    rd_chk(OFS_SHARED, 32'h0000_0000);
    rd_chk(OFS_DIV_LO, 32'h0000_0000);
    rd_chk(OFS_FCTL, 32'h0000_0000);
    foreach (rows[i]) begin
      wr(rows[i].adr, rows[i].wd);
      rd_chk(rows[i].adr, rows[i].exp);
    end
    // Filter on: a data frame is dropped and flags the drop event.
    wr(OFS_CSR, 32'h0000_0001);
    i_umb_node_model.xfer(9'h055, got);
    repeat (4) @(posedge SYS_CLK);
    rd_chk(OFS_IRQ_STS, 32'h0000_0004);
    check({31'h0, irq}, 32'h0000_0001);
    rd_chk(OFS_CSR, 32'h0000_0001);
    wr(OFS_IRQ_STS, 32'h0000_0007);
    repeat (2) @(posedge SYS_CLK);
    check({31'h0, irq}, 32'h0000_0000);
    i_umb_node_model.xfer(9'h1A3, got);
    rd_chk(OFS_CSR, 32'h0000_0081);
    rd_chk(OFS_IRQ_STS, 32'h0000_0001);
    rd_chk(OFS_DATA, 32'h0000_01A3);
    wr(OFS_CSR, 32'h0000_0000);
    i_umb_node_model.xfer(9'h03C, got);
    rd_chk(OFS_DATA, 32'h0000_003C);
    wr(OFS_CSR, 32'h0000_0001);
    i_umb_node_model.xfer(9'h066, got);
    rd_chk(OFS_DATA, 32'h0000_003C);
    // Transmit under both clock polarities.
    for (int p = 0; p < 2; p++) begin
      txv = (p == 0) ? 9'h1B5 : 9'h04E;
      pol <= p[0];
      wr(OFS_SHARED, 32'h0000_8050 | 32'(p));
      wr(OFS_DATA, {23'h0, txv});
      i_umb_node_model.xfer(9'h0AA, got);
      repeat (2) @(posedge SYS_CLK);
      check({23'h0, got}, {23'h0, txv});
      rd_chk(OFS_CSR, 32'h0000_0041);
      wr(OFS_CSR, 32'h0000_0041);
      rd_chk(OFS_CSR, 32'h0000_0001);
    end
    // Eight-bit frames: the first stop bit marks the frame type.
    wr(OFS_SHARED, 32'h0000_804F);
    i_umb_node_model.xfer(9'h1C3, got);
    rd_chk(OFS_DATA, 32'h0000_00C3);
    i_umb_node_model.xfer(9'h05A, got);
    rd_chk(OFS_DATA, 32'h0000_00C3);
    // A reset in mid-run puts the divisor, CSR and status registers back to reset; fctl is read only after a zero write.
    pol <= 1'b0;
    SYS_RST <= 1'b1;
    repeat (3) @(posedge SYS_CLK);
    SYS_RST <= 1'b0;
    @(posedge SYS_CLK);
    check({30'h0, txd, irq}, 32'h0000_0002);
    rd_chk(OFS_SHARED, 32'h0000_0000);
    rd_chk(OFS_DIV_LO, 32'h0000_0000);
    rd_chk(OFS_CSR, 32'h0000_0000);
    rd_chk(OFS_IRQ_STS, 32'h0000_0000);
    wr(OFS_SHARED, 32'h0000_8000);
    rd_chk(OFS_FCTL, 32'h0000_0000);
    rd_chk(OFS_SHARED, 32'h0000_0000);
    give_verdict();
  end

  initial begin
    #100000;
    fails++;
    give_verdict();
  end
endmodule
